// ==== tsg_trigger_gate.sv ====
// Trigger source selection, edge qualification and gating.
`timescale 1ns/100ps
module tsg_trigger_gate
  import tsg_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               front_trig_i,
  input  wire logic [7:0]         backplane_trig_i,
  input  wire logic               src_wr_i,
  input  wire tsg_pkg::tsg_src_e  src_i,
  input  wire tsg_pkg::tsg_line_t line_i,
  input  wire logic               slope_wr_i,
  input  wire logic               falling_edge_option_i,
  input  wire logic               combined_output_config_command_i,
  input  wire tsg_pkg::tsg_mode_e mode_i,
  input  wire logic               fsk_en_i,
  input  wire logic               bus_trig_i,
  input  wire logic               run_done_i,
  input  wire logic               wait_cmd_i,
  input  wire logic               opc_cmd_i,
  input  wire logic               opc_query_i,
  output logic                    run_start_o,
  output logic                    run_busy_o,
  output logic                    burst_gate_o,
  output logic                    fsk_hop_o,
  output logic                    cmd_stall_o,
  output logic                    opc_event_o,
  output logic                    opc_reply_valid_o,
  output logic                    opc_reply_o,
  output tsg_pkg::tsg_src_e       trigger_source_select_o,
  output tsg_pkg::tsg_line_t      line_sel_o,
  output logic                    falling_edge_sel_o
);

  import tsg_pkg::*;

  typedef enum logic [1:0] {
    TSG_ST_IDLE = 2'h1,
    TSG_ST_RUN  = 2'h2
  } tsg_st_e;

  // ==========================================================================
  // Synchronisers.
  logic [8:0] raw_in;
  logic [8:0] sync_in;
  logic       front_s;
  logic       bpl_s;
  logic       sel_s_r;

  assign raw_in = {backplane_trig_i, front_trig_i};

  tsg_sync #(.W(9)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (raw_in),
    .sync_o  (sync_in)
  );

  assign front_s = sync_in[0];
  assign bpl_s   = sync_in[1 + line_sel_o];

  // ==========================================================================
  // Settings storage.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trigger_source_select_o <= TSG_SRC_INT;
      line_sel_o              <= TSG_LINE_RST;
    end else if (combined_output_config_command_i) begin
      trigger_source_select_o <= TSG_SRC_INT;
    end else if (src_wr_i) begin
      trigger_source_select_o <= src_i;
      line_sel_o              <= line_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      falling_edge_sel_o <= TSG_FALL_RST;
    end else if (slope_wr_i) begin
      falling_edge_sel_o <= falling_edge_option_i;
    end
  end

  // ==========================================================================
  // Logical trigger level: backplane lines are ground-true, so inverted.
  logic trig_lvl;
  logic counted;
  logic edge_hit;
  logic trig_evt;

  function automatic logic edge_ok(input logic now, input logic prev,
                                   input logic fall);
    edge_ok = fall ? (prev & ~now) : (~prev & now);
  endfunction : edge_ok

  always_comb begin
    if (trigger_source_select_o == TSG_SRC_BPL) begin
      trig_lvl = ~bpl_s;
    end else begin
      trig_lvl = front_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_s_r <= 1'h0;
    end else begin
      sel_s_r <= trig_lvl;
    end
  end

  assign counted  = (mode_i == TSG_MODE_BURST) || (mode_i == TSG_MODE_SWEEP);
  assign edge_hit = edge_ok(trig_lvl, sel_s_r, falling_edge_sel_o);

  always_comb begin
    trig_evt = 1'b0;
    if (counted && !fsk_en_i) begin
      case (trigger_source_select_o)
        TSG_SRC_INT: trig_evt = 1'b1;
        TSG_SRC_EXT: trig_evt = edge_hit;
        TSG_SRC_BPL: trig_evt = edge_hit;
        TSG_SRC_BUS: trig_evt = bus_trig_i;
        default:     trig_evt = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Gating ignores the slope; internal and bus sources use the front panel.
  logic gate_lvl;

  assign gate_lvl = (trigger_source_select_o == TSG_SRC_BPL)
                    ? ~bpl_s : front_s;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      burst_gate_o <= 1'h0;
      fsk_hop_o    <= TSG_FSK_RST;
    end else begin
      burst_gate_o <= (mode_i == TSG_MODE_GATED) && !fsk_en_i
                      && gate_lvl;
      fsk_hop_o    <= fsk_en_i && gate_lvl;
    end
  end

  // ==========================================================================
  // Run sequencer.
  tsg_st_e st_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= TSG_ST_IDLE;
    end else begin
      case (st_r)
        TSG_ST_IDLE: if (trig_evt) begin
          st_r <= TSG_ST_RUN;
        end
        TSG_ST_RUN: if (run_done_i) begin
          st_r <= TSG_ST_IDLE;
        end
        default: st_r <= TSG_ST_IDLE;
      endcase
    end
  end

  assign run_start_o = (st_r == TSG_ST_IDLE) && trig_evt;
  assign run_busy_o  = (st_r == TSG_ST_RUN);

  // ==========================================================================
  // Synchronisation commands.
  logic wait_r;
  logic opc_arm_r;
  logic opcq_arm_r;
  logic done_now;

  assign done_now = run_busy_o && run_done_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'h0;
    end else if (wait_cmd_i && (run_busy_o || run_start_o) && !done_now) begin
      wait_r <= 1'h1;
    end else if (done_now) begin
      wait_r <= 1'h0;
    end
  end

  assign cmd_stall_o = wait_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      opc_arm_r         <= 1'h0;
      opcq_arm_r        <= 1'h0;
      opc_event_o       <= 1'h0;
      opc_reply_valid_o <= 1'h0;
      opc_reply_o       <= 1'h0;
    end else begin
      opc_event_o       <= 1'h0;
      opc_reply_valid_o <= 1'h0;
      if (done_now && (opc_arm_r || opc_cmd_i)) begin
        opc_event_o <= 1'h1;
        opc_arm_r   <= 1'h0;
      end else if (opc_cmd_i) begin
        opc_arm_r <= 1'h1;
      end
      if (done_now && (opcq_arm_r || opc_query_i)) begin
        opc_reply_valid_o <= 1'h1;
        opc_reply_o       <= TSG_OPC_REPLY;
        opcq_arm_r        <= 1'h0;
      end else if (opc_query_i) begin
        opcq_arm_r <= 1'h1;
      end
    end
  end

  // ==========================================================================
  // Assertions.
  sequence start_seq;
    run_start_o;
  endsequence

  sequence busy_seq;
    run_busy_o;
  endsequence

  // Idle in a counted mode with an unchanged source and line selection.
  sequence ready_seq;
    counted && !fsk_en_i && !run_busy_o
      && $stable(trigger_source_select_o) && $stable(line_sel_o);
  endsequence

  start_busy_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    start_seq |=> busy_seq)
    else $error("Busy did not follow start.");

  no_retrig_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    run_busy_o |-> !run_start_o)
    else $error("Start while busy.");

  cfg_force_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    combined_output_config_command_i |=>
      trigger_source_select_o == TSG_SRC_INT)
    else $error("Config command did not select internal source.");

  int_cont_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (trigger_source_select_o == TSG_SRC_INT && counted && !fsk_en_i
     && !run_busy_o) |-> run_start_o)
    else $error("Internal source failed to start.");

  bus_only_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (trigger_source_select_o == TSG_SRC_BUS && !bus_trig_i) |-> !run_start_o)
    else $error("Bus source started without trigger.");

  fsk_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (fsk_en_i && trigger_source_select_o != TSG_SRC_BPL)
      |=> fsk_hop_o == $past(front_s))
    else $error("FSK hop not following front panel.");

  off_mode_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_i == TSG_MODE_OFF || mode_i == TSG_MODE_GATED) |-> !run_start_o)
    else $error("Start outside counted modes.");

  opc_done_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (done_now && opc_arm_r) |=> opc_event_o)
    else $error("Completion event missing.");

  wait_clr_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (wait_r && done_now) |=> !cmd_stall_o)
    else $error("Stall held after completion.");

  front_rise_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ready_seq ##0 (trigger_source_select_o == TSG_SRC_EXT
      && !falling_edge_sel_o && $rose(front_s)) |-> start_seq)
    else $error("Rising front edge did not start a run.");

  front_fall_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ready_seq ##0 (trigger_source_select_o == TSG_SRC_EXT
      && falling_edge_sel_o && $fell(front_s)) |-> start_seq)
    else $error("Falling front edge did not start a run.");

  line_edge_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ready_seq ##0 (trigger_source_select_o == TSG_SRC_BPL
      && !falling_edge_sel_o && $fell(bpl_s)) |-> start_seq)
    else $error("Falling backplane line did not start a run.");

  gate_sense_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (mode_i == TSG_MODE_GATED && !fsk_en_i
     && trigger_source_select_o != TSG_SRC_BPL)
      |=> burst_gate_o == $past(front_s))
    else $error("Gate not following front panel level.");

  reset_src_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> (trigger_source_select_o == TSG_SRC_INT
      && line_sel_o == TSG_LINE_RST))
    else $error("Reset did not select internal source.");

endmodule : tsg_trigger_gate

// ==== tsg_pkg.sv ====
// Constants and types for the trigger source gate select block.
//
// Contract
// - Trigger logic acts only in burst, FSK and sweep modes; four source kinds.
// - Gated burst and FSK use the selected input as a level gate.
// - When gating, the edge-polarity setting is ignored entirely.
// - Front-panel input triggers on rising or falling edge per option.
// - Backplane lines act like front panel, with inverted electrical polarity.
// - Any of eight backplane lines, zero through seven, may be selected.
// - Reset selects the internal always-true source; selection is volatile.
// - Internal source runs bursts or sweeps continuously when enabled.
// - Combined output-configuration command forces internal source.
// - Front-panel source gives exactly one burst or sweep per qualifying edge.
// - Bus trigger starts one counted burst or sweep; no effect on gating.
// - Wait command stalls later commands until the burst or sweep completes.
// - Completion after operation-complete sets event bit 0 or queues reply 1.
// - FSK with internal or bus source takes its control from front panel.
// - Edge and source settings are readable back.
package tsg_pkg;

  // ==========================================================================
  // Source and mode encodings.
  typedef enum logic [1:0] {
    TSG_SRC_INT  = 2'h0,
    TSG_SRC_EXT  = 2'h1,
    TSG_SRC_BUS  = 2'h2,
    TSG_SRC_BPL  = 2'h3
  } tsg_src_e;

  typedef enum logic [1:0] {
    TSG_MODE_OFF    = 2'h0,
    TSG_MODE_BURST  = 2'h1,
    TSG_MODE_GATED  = 2'h2,
    TSG_MODE_SWEEP  = 2'h3
  } tsg_mode_e;

  typedef logic [2:0] tsg_line_t;

  // ==========================================================================
  // Fixed widths, reset values and timing.
  localparam int        TSG_NUM_LINES   = 8;
  localparam tsg_line_t TSG_LINE_RST    = 3'h0;
  localparam logic      TSG_FALL_RST    = 1'h0;
  localparam logic      TSG_FSK_RST     = 1'h0;
  localparam int        TSG_CLK_NS      = 10;
  localparam int        TSG_MIN_PER_NS  = 2000;
  localparam int        TSG_MIN_PER_CYC = (TSG_MIN_PER_NS + TSG_CLK_NS - 1)
                                          / TSG_CLK_NS;
  localparam logic      TSG_OPC_REPLY   = 1'h1;
  localparam int        TSG_OPC_BIT     = 0;

endpackage : tsg_pkg

// ==== tsg_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous inputs.
`timescale 1ns/100ps
module tsg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // Stage one is read only by stage two.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : tsg_sync

// ==== tsg_far_model.sv ====
// Far-side model: trigger equipment, backplane lines and run generator.
`timescale 1ns/100ps
module tsg_far_model (
  input  wire logic       clk_i,
  input  wire logic       run_busy_i,
  output logic            front_trig_o,
  output logic [7:0]      backplane_trig_o,
  output logic            run_done_o
);
  int unsigned dly = 2;

  initial begin
    front_trig_o     = 1'b0;
    backplane_trig_o = 8'hff;
    run_done_o       = 1'b0;
  end

  // The generator ends each run after dly cycles, and only while busy.
  initial forever begin
    @(posedge clk_i);
    #1;
    if (run_busy_i === 1'b1) begin
      repeat (dly) @(posedge clk_i);
      #1 run_done_o = 1'b1;
      @(posedge clk_i);
      #1 run_done_o = 1'b0;
    end
  end

  task automatic level(input logic v);
    front_trig_o = v;
  endtask : level

  // A negative line selects the front panel; backplane lines rest high.
  task automatic pulse(input int line, input int width);
    if (line < 0) front_trig_o = 1'b1;
    else backplane_trig_o[line] = 1'b0;
    repeat (width) @(posedge clk_i);
    #1 front_trig_o = 1'b0;
    backplane_trig_o = 8'hff;
    repeat (tsg_pkg::TSG_MIN_PER_CYC) @(posedge clk_i);
    #1;
  endtask : pulse
endmodule : tsg_far_model

// ==== tb_trigger_source_gate_select.sv ====
// Self-checking bench for the trigger source gate select block.
`timescale 1ns/100ps
module tb_trigger_source_gate_select;
  import tsg_pkg::*;
  logic      clk_i, rst_n_i, front_trig_i, src_wr_i, slope_wr_i;
  logic      falling_edge_option_i, combined_output_config_command_i;
  logic      fsk_en_i, bus_trig_i, run_done_i, wait_cmd_i, opc_cmd_i;
  logic      opc_query_i, run_start_o, run_busy_o, burst_gate_o, fsk_hop_o;
  logic      cmd_stall_o, opc_event_o, opc_reply_valid_o, opc_reply_o;
  logic      falling_edge_sel_o;
  logic [7:0] backplane_trig_i;
  tsg_src_e  src_i, trigger_source_select_o;
  tsg_line_t line_i, line_sel_o, lsel;
  tsg_mode_e mode_i;
  tsg_src_e  exp_q[$];
  bit        free_run;
  int        n_free, n_errors, cmp_count;

  tsg_trigger_gate DUT (.clk_i, .rst_n_i, .front_trig_i, .backplane_trig_i,
    .src_wr_i, .src_i, .line_i, .slope_wr_i, .falling_edge_option_i,
    .combined_output_config_command_i, .mode_i, .fsk_en_i, .bus_trig_i,
    .run_done_i, .wait_cmd_i, .opc_cmd_i, .opc_query_i, .run_start_o,
    .run_busy_o, .burst_gate_o, .fsk_hop_o, .cmd_stall_o, .opc_event_o,
    .opc_reply_valid_o, .opc_reply_o, .trigger_source_select_o,
    .line_sel_o, .falling_edge_sel_o);

  tsg_far_model P (.clk_i, .run_busy_i(run_busy_o),
    .front_trig_o(front_trig_i), .backplane_trig_o(backplane_trig_i),
    .run_done_o(run_done_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Checking tasks and the start monitor.
  task automatic fail(input string what);
    n_errors++;
    $display("Error at %0t: %s", $time, what);
  endtask : fail

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  task automatic wait_idle();
    int i;
    for (i = 0; i < 1000 && run_busy_o !== 1'b0; i++) step();
    if (i == 1000) begin
      fail("run never ended");
      conclude();
    end
  endtask : wait_idle

  task automatic set_cfg(input tsg_src_e s, input tsg_line_t l,
                         input logic f);
    src_i = s;
    line_i = l;
    src_wr_i = 1'b1;
    step();
    src_wr_i = 1'b0;
    falling_edge_option_i = f;
    slope_wr_i = 1'b1;
    step();
    slope_wr_i = 1'b0;
    chk(falling_edge_sel_o, f, "slope readback");
    chk(trigger_source_select_o, s, "source readback");
  endtask : set_cfg

  always @(posedge clk_i) begin
    if (rst_n_i === 1'b1 && run_start_o === 1'b1) begin
      if (free_run) n_free++;
      else if (exp_q.size() == 0) fail("unexpected run start");
      else chk(trigger_source_select_o, exp_q.pop_front(), "source");
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {rst_n_i, src_wr_i, slope_wr_i, falling_edge_option_i, fsk_en_i} = '0;
    {combined_output_config_command_i, bus_trig_i, wait_cmd_i} = '0;
    {opc_cmd_i, opc_query_i} = '0;
    src_i = TSG_SRC_INT;
    line_i = TSG_LINE_RST;
    mode_i = TSG_MODE_OFF;
    void'($urandom(32'h5670d600));
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    step();
    chk(trigger_source_select_o, TSG_SRC_INT, "reset source");
    chk(line_sel_o, TSG_LINE_RST, "reset line");
    chk(falling_edge_sel_o, TSG_FALL_RST, "reset slope");
    free_run = 1'b1;
    mode_i = TSG_MODE_SWEEP;
    repeat (40) step();
    mode_i = TSG_MODE_OFF;
    wait_idle();
    step();
    free_run = 1'b0;
    chk(n_free > 2, 1'b1, "free running starts");
    set_cfg(TSG_SRC_BUS, TSG_LINE_RST, 1'b0);
    mode_i = TSG_MODE_BURST;
    P.dly = 10 + $urandom % 10;
    exp_q.push_back(TSG_SRC_BUS);
    bus_trig_i = 1'b1;
    step();
    step();
    {bus_trig_i, wait_cmd_i, opc_cmd_i, opc_query_i} = 4'h7;
    step();
    {wait_cmd_i, opc_cmd_i, opc_query_i} = 3'h0;
    chk(cmd_stall_o, 1'b1, "stall during run");
    wait_idle();
    chk(exp_q.size(), 0, "one start per bus trigger");
    chk({opc_event_o, opc_reply_valid_o, opc_reply_o}, 3'h7, "opc");
    chk(cmd_stall_o, 1'b0, "stall released");
    fsk_en_i = 1'b1;
    bus_trig_i = 1'b1;
    step();
    bus_trig_i = 1'b0;
    P.level(1'b1);
    repeat (4) step();
    chk(fsk_hop_o, 1'b1, "hop from front panel");
    P.level(1'b0);
    repeat (4) step();
    chk(fsk_hop_o, 1'b0, "carrier from front panel");
    fsk_en_i = 1'b0;
    P.dly = 1 + $urandom % 20;
    for (int f = 0; f < 2; f++) begin
      set_cfg(TSG_SRC_EXT, TSG_LINE_RST, f[0]);
      exp_q.push_back(TSG_SRC_EXT);
      P.pulse(-1, 50);
      chk(exp_q.size(), 0, "one start per front edge");
    end
    lsel = tsg_line_t'($urandom % TSG_NUM_LINES);
    set_cfg(TSG_SRC_BPL, lsel, 1'b0);
    chk(line_sel_o, lsel, "line readback");
    P.pulse(int'(lsel ^ 3'h1), 30);
    exp_q.push_back(TSG_SRC_BPL);
    P.pulse(int'(lsel), 30);
    chk(exp_q.size(), 0, "one start per line edge");
    set_cfg(TSG_SRC_EXT, TSG_LINE_RST, 1'b1);
    mode_i = TSG_MODE_GATED;
    P.level(1'b1);
    repeat (4) step();
    chk(burst_gate_o, 1'b1, "gate open");
    P.level(1'b0);
    repeat (4) step();
    chk(burst_gate_o, 1'b0, "gate shut");
    mode_i = TSG_MODE_OFF;
    src_i = TSG_SRC_BUS;
    {src_wr_i, combined_output_config_command_i} = 2'h3;
    step();
    {src_wr_i, combined_output_config_command_i} = 2'h0;
    chk(trigger_source_select_o, TSG_SRC_INT, "forced internal");
    conclude();
  end
endmodule : tb_trigger_source_gate_select
